// ==== rtl/sto_timer.sv ====
// Supervisor time-out timer with register port and timer reset output
`timescale 1ns/1ns
module sto_timer
  import sto_pkg::*;
#(
  parameter logic [LIM_W-1:0] INTERVAL1_CLKS = 22'h008000,
  parameter logic [LIM_W-1:0] INTERVAL2_CLKS = 22'h040000,
  parameter logic [LIM_W-1:0] INTERVAL3_CLKS = 22'h200000
) (
  // Clock and power-on reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Other reset sources
  input  wire logic              pf_rst,
  input  wire logic              ext_rst,
  // Register port
  input  wire logic [STO_AW-1:0] addr,
  input  wire logic [STO_DW-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [STO_DW-1:0]      rd_data,
  // Outputs
  output logic                   wdt_sys_rst,
  output logic                   wdt_irq_req,
  output logic                   irq
);

  // Selects the interval length from the two select bits
  function automatic logic [LIM_W-1:0] sto_limit(input logic [1:0] sel);
    logic [LIM_W-1:0] lim;
    lim = INTERVAL0_CLKS;
    case (sel)
      2'h1:    lim = INTERVAL1_CLKS;
      2'h2:    lim = INTERVAL2_CLKS;
      2'h3:    lim = INTERVAL3_CLKS;
      default: lim = INTERVAL0_CLKS;
    endcase
    return lim;
  endfunction : sto_limit

  // Sticky bit update: a set in the same cycle beats the clear
  function automatic logic sto_sticky(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : sto_sticky

  // Registers
  sto_state_t         state_ff;
  sto_state_t         nxt_state;
  logic               roe_ff;
  logic               tof_ff;
  logic               rcf_ff;
  logic               glb_ff;
  logic               run_ff;
  logic [STO_DW-1:0]  clk_cfg_ff;
  logic [STO_DW-1:0]  xie_ff;
  logic [STS_W-1:0]   sts_ff;
  logic [STS_W-1:0]   msk_ff;
  logic [GRACE_W-1:0] grace_ff;
  logic [HOLD_W-1:0]  hold_ff;
  logic [STO_DW-1:0]  rd_data_ff;

  // Next values
  logic               nxt_tof;
  logic               nxt_rcf;
  logic [STS_W-1:0]   nxt_sts;
  logic [GRACE_W-1:0] nxt_grace;
  logic [HOLD_W-1:0]  nxt_hold;
  logic [STO_DW-1:0]  nxt_rd_data;

  // Address decode
  wire hit_sup = (addr == ADDR_SUP);
  wire hit_clk = (addr == ADDR_CLK);
  wire hit_xie = (addr == ADDR_XIE);
  wire hit_ien = (addr == ADDR_IEN);
  wire hit_sts = (addr == ADDR_STS);
  wire hit_msk = (addr == ADDR_MSK);
  wire wr_sup  = wr_en && hit_sup;
  wire wr_clk  = wr_en && hit_clk;
  wire wr_xie  = wr_en && hit_xie;
  wire wr_ien  = wr_en && hit_ien;
  wire wr_sts  = wr_en && hit_sts;
  wire wr_msk  = wr_en && hit_msk;

  // Power-on and power-fail both disable the timer
  wire por_any = rst || pf_rst;

  // Restart strobe acts only on a written one and is never stored
  wire restart = wr_sup && wr_data[SUP_RST];

  // Interval counter
  logic             expire;
  wire  [1:0]       sel      = {clk_cfg_ff[CLK_SEL_HI], clk_cfg_ff[CLK_SEL_LO]};
  wire  [LIM_W-1:0] limit    = sto_limit(sel);
  wire              in_hold  = (state_ff == ST_HOLD);
  wire              div_run  = run_ff && (state_ff != ST_IDLE) && !in_hold;
  wire              div_clr  = restart || ext_rst || in_hold;

  sto_divider u_div (
    .mclk   (mclk),
    .rst    (por_any),
    .clear  (div_clr),
    .run    (div_run),
    .limit  (limit),
    .expire (expire),
    .count  ()
  );

  // Grace window and reset hold
  wire in_grace   = (state_ff == ST_GRACE);
  wire grace_done = in_grace && (grace_ff == GRACE_CLKS - 1'b1);
  wire trip       = grace_done && roe_ff && !restart && !ext_rst;
  wire hold_done  = in_hold && (hold_ff == HOLD_CLKS - 1'b1);

  assign nxt_grace = (in_grace && !restart && !ext_rst) ? grace_ff + 1'b1 : '0;
  assign nxt_hold  = in_hold ? hold_ff + 1'b1 : '0;

  // Supervisor sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (run_ff) begin
          nxt_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!run_ff) begin
          nxt_state = ST_IDLE;
        end else if (expire) begin
          nxt_state = ST_GRACE;
        end
      end
      ST_GRACE: begin
        if (!run_ff) begin
          nxt_state = ST_IDLE;
        end else if (restart || ext_rst) begin
          nxt_state = ST_COUNT;
        end else if (trip) begin
          nxt_state = ST_HOLD;
        end else if (grace_done) begin
          nxt_state = ST_COUNT;
        end
      end
      ST_HOLD: begin
        if (hold_done) begin
          nxt_state = ST_COUNT;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Flags: time-out set by an expiry unless a trip in the same cycle clears it, cleared by write of 0 or a reset
  wire tof_sw_clr = wr_sup && !wr_data[SUP_TOF];
  wire rcf_sw_clr = wr_sup && !wr_data[SUP_RCF];
  assign nxt_tof = (ext_rst || trip) ? 1'b0
                 : sto_sticky(tof_ff, expire, tof_sw_clr);
  assign nxt_rcf = sto_sticky(rcf_ff, trip, rcf_sw_clr);

  // Event status, write one to clear
  wire [STS_W-1:0] sts_set = {trip, expire};
  wire [STS_W-1:0] sts_clr = wr_sts ? wr_data[STS_W-1:0] : '0;
  assign nxt_sts = sts_set | (sts_ff & ~sts_clr);

  // Read data
  wire [STO_DW-1:0] sup_val = {4'h0, tof_ff, rcf_ff, roe_ff, 1'b0};
  wire [STO_DW-1:0] ien_val = {glb_ff, 6'h00, run_ff};
  wire [STO_DW-1:0] rd_mux  = hit_sup ? sup_val
                            : hit_clk ? clk_cfg_ff
                            : hit_xie ? xie_ff
                            : hit_ien ? ien_val
                            : hit_sts ? {6'h00, sts_ff}
                            : hit_msk ? {6'h00, msk_ff}
                            : 8'h00;
  assign nxt_rd_data = rd_en ? rd_mux : 8'h00;

  // Sequence and counters
  always_ff @(posedge mclk) begin
    if (por_any) begin
      state_ff <= ST_IDLE;
      grace_ff <= '0;
      hold_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      grace_ff <= nxt_grace;
      hold_ff  <= nxt_hold;
    end
  end

  // Flags
  always_ff @(posedge mclk) begin
    if (por_any) begin
      tof_ff <= 1'b0;
      rcf_ff <= 1'b0;
      sts_ff <= STS_RST;
    end else begin
      tof_ff <= nxt_tof;
      rcf_ff <= nxt_rcf;
      sts_ff <= nxt_sts;
    end
  end

  // Software settings
  always_ff @(posedge mclk) begin
    if (por_any) begin
      roe_ff     <= 1'b0;
      run_ff     <= 1'b0;
      glb_ff     <= 1'b0;
      clk_cfg_ff <= CLK_CFG_RST;
      xie_ff     <= XIE_RST;
      msk_ff     <= STS_RST;
    end else begin
      if (wr_sup) begin
        roe_ff <= wr_data[SUP_ROE];
      end
      if (wr_ien) begin
        run_ff <= wr_data[IEN_RUN];
        glb_ff <= wr_data[IEN_GLB];
      end
      if (wr_clk) begin
        clk_cfg_ff <= wr_data;
      end
      if (wr_xie) begin
        xie_ff <= wr_data;
      end
      if (wr_msk) begin
        msk_ff <= wr_data[STS_W-1:0];
      end
    end
  end

  // Read data register
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Outputs
  assign rd_data     = rd_data_ff;
  assign wdt_sys_rst = in_hold;
  assign wdt_irq_req = tof_ff && xie_ff[XIE_TO] && glb_ff;
  assign irq         = |(sts_ff & msk_ff);

endmodule : sto_timer

// ==== include/sto_pkg.sv ====
// Constants and types shared by the supervisor time-out timer
package sto_pkg;

  // Register port widths
  localparam int STO_AW = 8;
  localparam int STO_DW = 8;

  // Register byte addresses
  localparam logic [STO_AW-1:0] ADDR_SUP = 8'h00;
  localparam logic [STO_AW-1:0] ADDR_CLK = 8'h04;
  localparam logic [STO_AW-1:0] ADDR_XIE = 8'h08;
  localparam logic [STO_AW-1:0] ADDR_IEN = 8'h0C;
  localparam logic [STO_AW-1:0] ADDR_STS = 8'h10;
  localparam logic [STO_AW-1:0] ADDR_MSK = 8'h14;

  // Supervisor control field positions
  localparam int SUP_TOF = 3;
  localparam int SUP_RCF = 2;
  localparam int SUP_ROE = 1;
  localparam int SUP_RST = 0;

  // Clock configuration: interval select field
  localparam int CLK_SEL_HI = 7;
  localparam int CLK_SEL_LO = 6;

  // Interrupt enable positions
  localparam int XIE_TO  = 5;
  localparam int IEN_GLB = 7;
  localparam int IEN_RUN = 0;

  // Interrupt status / mask positions
  localparam int STS_W    = 2;
  localparam int STS_EXP  = 0;
  localparam int STS_TRST = 1;

  // Reset values
  localparam logic [STO_DW-1:0] CLK_CFG_RST = 8'h00;
  localparam logic [STO_DW-1:0] XIE_RST     = 8'h00;
  localparam logic [STS_W-1:0]  STS_RST     = 2'h0;

  // Interval counter
  localparam int CNT_W = 21;
  localparam int LIM_W = 22;
  localparam logic [LIM_W-1:0] INTERVAL0_CLKS = 22'h001000;

  // Grace window after an expiry
  localparam int GRACE_W = 10;
  localparam logic [GRACE_W-1:0] GRACE_CLKS = 10'h200;

  // Timer reset pulse length
  localparam int HOLD_W = 4;
  localparam int MCYC_CLKS = 4;
  localparam int HOLD_MCYC = 2;
  localparam logic [HOLD_W-1:0] HOLD_CLKS = HOLD_W'(MCYC_CLKS * HOLD_MCYC);

  // Supervisor states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COUNT,
    ST_GRACE,
    ST_HOLD
  } sto_state_t;

endpackage : sto_pkg

// ==== rtl/sto_divider.sv ====
// Interval divider: counts clocks and pulses at the selected limit
`timescale 1ns/1ns
module sto_divider
  import sto_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Control
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [LIM_W-1:0] limit,
  // Status
  output logic                  expire,
  output logic [CNT_W-1:0]      count
);

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  wire              at_end = (count_ff == CNT_W'(limit - 1'b1));

  // Wrap at the limit so the timer keeps running freely
  assign nxt_count = (clear || !run || at_end) ? '0 : count_ff + 1'b1;
  assign expire    = run && !clear && at_end;
  assign count     = count_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule : sto_divider

// ==== tb/sto_timer_asserts.sv ====
// Port checker for the supervisor time-out timer
`timescale 1ns/1ns
module sto_timer_asserts
  import sto_pkg::*;
(
  // Clock and resets
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              pf_rst,
  input wire logic              ext_rst,
  // Register port
  input wire logic [STO_AW-1:0] addr,
  input wire logic [STO_DW-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [STO_DW-1:0] rd_data,
  // Outputs
  input wire logic              wdt_sys_rst,
  input wire logic              wdt_irq_req,
  input wire logic              irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic wr_sup = wr_en && addr == ADDR_SUP;
  wire logic wr_xie = wr_en && addr == ADDR_XIE;
  wire logic wr_ien = wr_en && addr == ADDR_IEN;
  property p_rd_idle; !rd_en |=> rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_sup; rd_en && addr == ADDR_SUP |=> rd_data[7:4] == 4'h0 && !rd_data[SUP_RST];
  endproperty
  a_rd_sup: assert property (p_rd_sup) else $error("restart bit read back");
  // A power-on or power-fail reset may cut the pulse short
  property p_hold; disable iff (rst || pf_rst || ext_rst)
    $rose(wdt_sys_rst) |-> wdt_sys_rst [*8] ##1 !wdt_sys_rst; endproperty
  a_hold: assert property (p_hold) else $error("reset pulse length");
  property p_pwr; pf_rst |=> !wdt_sys_rst && !wdt_irq_req && !irq; endproperty
  a_pwr: assert property (p_pwr) else $error("power reset outputs");
  property p_xie; wr_xie && !wr_data[XIE_TO] |=> !wdt_irq_req; endproperty
  a_xie: assert property (p_xie) else $error("request without enable");
  property p_glb; wr_ien && !wr_data[IEN_GLB] |=> !wdt_irq_req; endproperty
  a_glb: assert property (p_glb) else $error("request without global");
  property p_ext; ext_rst |=> !wdt_irq_req; endproperty
  a_ext: assert property (p_ext) else $error("flag kept over reset");
  property p_hold_flag; wdt_sys_rst |-> !wdt_irq_req; endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("flag kept in reset");
  property p_roe; wr_sup && !wr_data[SUP_ROE] |=> ##1 !$rose(wdt_sys_rst); endproperty
  a_roe: assert property (p_roe) else $error("reset while disabled");
  c_rst: cover property ($rose(wdt_sys_rst));
  c_req: cover property ($rose(wdt_irq_req));
  c_irq: cover property ($rose(irq));
endmodule : sto_timer_asserts

// ==== tb/test_supervisor_timeout_timer.sv ====
// Self-checking bench for the supervisor time-out timer
`timescale 1ns/1ns
module test_supervisor_timeout_timer;
  import sto_pkg::*;
  logic              mclk    = 1'b0;
  logic              rst     = 1'b1;
  logic              pf_rst  = 1'b0;
  logic              ext_rst = 1'b0;
  logic [STO_AW-1:0] addr    = 8'h00;
  logic [STO_DW-1:0] wr_data = 8'h00;
  logic              wr_en   = 1'b0;
  logic              rd_en   = 1'b0;
  logic [STO_DW-1:0] rd_data;
  logic              wdt_sys_rst;
  logic              wdt_irq_req;
  logic              irq;
  int                failures = 0;
  int                checks   = 0;
  int                n;
  int                lim [4]  = '{4096, 64, 128, 256};

  always #50 mclk = ~mclk;

  sto_timer #(.INTERVAL1_CLKS(22'h000040), .INTERVAL2_CLKS(22'h000080),
    .INTERVAL3_CLKS(22'h000100)) dut (.mclk(mclk), .rst(rst), .pf_rst(pf_rst),
    .ext_rst(ext_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .wdt_sys_rst(wdt_sys_rst), .wdt_irq_req(wdt_irq_req), .irq(irq));

  task conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp8

  task cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1

  task cmpn(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, lo);
    end
  endtask : cmpn

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    cmp8(rd_data, exp);
  endtask : rdc

  // Counts cycles until irq (w=0) or the timer reset (w=1)
  task wt(input bit w);
    n = 0;
    while ((w ? wdt_sys_rst : irq) !== 1'b1 && n < 6000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 6000) begin
      failures++;
      conclude();
    end
  endtask : wt

  task s_regs;
    for (int i = 0; i < 7; i++) rdc(STO_AW'(i * 4), 8'h00);
    wr(ADDR_CLK, 8'hFF);
    rdc(ADDR_CLK, 8'hFF);
    wr(ADDR_SUP, 8'h0B);
    rdc(ADDR_SUP, 8'h02);
    wr(8'h18, 8'hFF);
    rdc(8'h18, 8'h00);
    wr(ADDR_SUP, 8'h00);
  endtask : s_regs

  task s_intervals;
    wr(ADDR_MSK, 8'h01);
    wr(ADDR_IEN, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CLK, {i[1:0], 6'h00});
      wr(ADDR_SUP, 8'h01);
      wr(ADDR_STS, 8'h03);
      wt(0);
      cmpn(n, lim[i] - 6, lim[i] + 2);
    end
    wr(ADDR_STS, 8'h03);
    wt(0);
    cmpn(n, 248, 258);
  endtask : s_intervals

  task s_irq;
    wr(ADDR_CLK, 8'h40);
    wr(ADDR_XIE, 8'h20);
    wr(ADDR_IEN, 8'h81);
    wr(ADDR_STS, 8'h03);
    wt(0);
    cmp1(wdt_irq_req, 1'b1);
    wr(ADDR_IEN, 8'h01);
    cmp1(wdt_irq_req, 1'b0);
    wr(ADDR_IEN, 8'h81);
    wr(ADDR_XIE, 8'h00);
    cmp1(wdt_irq_req, 1'b0);
    wr(ADDR_XIE, 8'h20);
    wr(ADDR_SUP, 8'h00);
    cmp1(wdt_irq_req, 1'b0);
    wr(ADDR_STS, 8'h03);
    wt(0);
    @(posedge mclk);
    ext_rst <= 1'b1;
    @(posedge mclk);
    ext_rst <= 1'b0;
    #1;
    cmp1(wdt_irq_req, 1'b0);
    wr(ADDR_MSK, 8'h00);
    cmp1(irq, 1'b0);
    wr(ADDR_MSK, 8'h01);
    wr(ADDR_IEN, 8'h01);
  endtask : s_irq

  task s_wdt;
    wr(ADDR_SUP, 8'h03);
    wr(ADDR_STS, 8'h03);
    wt(0);
    wt(1);
    cmpn(n, 506, 514);
    rdc(ADDR_SUP, 8'h06);
    wr(ADDR_STS, 8'h03);
    wt(0);
    cmpn(n, 55, 80);
    repeat (100) @(posedge mclk);
    wr(ADDR_SUP, 8'h07);
    wt(1);
    cmpn(n, 565, 590);
    wr(ADDR_SUP, 8'h04);
    wr(ADDR_STS, 8'h03);
    repeat (700) @(posedge mclk);
    rdc(ADDR_SUP, 8'h0C);
    rdc(ADDR_STS, 8'h01);
  endtask : s_wdt

  task s_pwr;
    @(posedge mclk);
    pf_rst <= 1'b1;
    @(posedge mclk);
    pf_rst <= 1'b0;
    rdc(ADDR_SUP, 8'h00);
    rdc(ADDR_IEN, 8'h00);
    rdc(ADDR_CLK, 8'h00);
  endtask : s_pwr

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    s_regs();
    s_intervals();
    s_irq();
    s_wdt();
    s_pwr();
    conclude();
  end
endmodule : test_supervisor_timeout_timer

bind sto_timer sto_timer_asserts u_chk (.mclk(mclk), .rst(rst), .pf_rst(pf_rst),
  .ext_rst(ext_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .wdt_sys_rst(wdt_sys_rst), .wdt_irq_req(wdt_irq_req), .irq(irq));
